// >>> src/nes_pkg.sv
/*
  Package for the flash erase and unsecure command sequencer: register
  offsets, field positions, command codes, reset values and timing.
  Assumes a 40 MHz system clock and an Avalon-MM slave with 32-bit data.
*/
package nes_pkg;
  localparam logic [3:0]  OFS_STATUS     = 4'h0;
  localparam logic [3:0]  OFS_INDEX      = 4'h1;
  localparam logic [3:0]  OFS_PARAM      = 4'h2;
  localparam logic [3:0]  OFS_IRQ_MASK   = 4'h3;
  localparam logic [3:0]  OFS_CONFIG     = 4'h4;
  localparam logic [3:0]  OFS_SECURITY   = 4'h5;

  localparam int BIT_COMPLETE  = 7;
  localparam int BIT_ACC_ERR   = 5;
  localparam int BIT_PROT_VIOL = 4;
  localparam int BIT_VERR      = 1;
  localparam int BIT_VUNC      = 0;
  localparam int BIT_DONE      = 0;
  localparam int BIT_SECURE    = 1;

  localparam int BIT_PROT_FLASH = 0;
  localparam int BIT_PROT_EE    = 1;
  localparam int BIT_MODE_OK    = 2;
  localparam int BIT_FAIL_VER   = 3;
  localparam int BIT_FAIL_UNC   = 4;

  localparam logic [7:0] CMD_ERASE_BLOCK  = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE     = 8'h0B;

  localparam logic [2:0] IDX_FIRST  = 3'h0;
  localparam logic [2:0] IDX_SECOND = 3'h1;
  localparam logic [2:0] IDX_LAST   = 3'h7;

  localparam logic [7:0] BLK_FLASH = 8'h00;
  localparam logic [7:0] BLK_EE    = 8'h80;

  localparam logic [7:0] CFG_RESET = 8'h04;
  localparam logic [1:0] ALIGN_OK  = 2'h0;

  localparam int ERASE_NS_PER_ADDR = 100;
  localparam int CLK_NS            = 25;
  localparam int ERASE_CYC_PER_ADDR =
    (ERASE_NS_PER_ADDR + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ERASE  = 3'b001,
    ST_VERIFY = 3'b011,
    ST_FINISH = 3'b010
  } nes_state_type;

  typedef struct packed {
    logic verr;
    logic vunc;
  } nes_verify_type;

  typedef struct packed {
    logic access_err;
    logic prot_viol;
  } nes_check_type;
endpackage

// >>> src/nes_erase_seq.sv
/*
  Erase-block, erase-sector and unsecure command sequencer with its
  registers on an Avalon-MM slave with waitrequest.
  Assumes a single 40 MHz clock and a synchronous host bus master.
*/
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module nes_erase_seq #(
  parameter int FLASH_WORDS  = 1024,
  parameter int EE_WORDS     = 64,
  parameter int SECTOR_WORDS = 128
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out,
  output logic             secure_out
);
  localparam int CW = $clog2(FLASH_WORDS + EE_WORDS + 1) + 1;

  logic                rst_meta;
  logic                rst_sync_b;
  nes_pkg::nes_state_type state;
  logic [2:0]          command_word_index;
  logic [15:0]         command_parameter_words [0:7];
  logic                command_complete_flag;
  logic                access_error_flag;
  logic                protection_violation_flag;
  logic                verify_error_flag;
  logic                verify_uncorrectable_flag;
  logic [7:0]          cfg;
  logic                secure;
  logic                done_sticky;
  logic                done_mask;
  logic                is_unsec;
  logic [CW-1:0]       work_cnt;
  logic [7:0]          tick_cnt;

  // Reset is released through two flops.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  wire        wr_acc   = avs_write_in && !avs_waitrequest_out;
  wire        wr_stat  = wr_acc && avs_address_in == nes_pkg::OFS_STATUS;
  wire        wr_idx   = wr_acc && avs_address_in == nes_pkg::OFS_INDEX;
  wire        wr_par   = wr_acc && avs_address_in == nes_pkg::OFS_PARAM;
  wire        wr_mask  = wr_acc && avs_address_in == nes_pkg::OFS_IRQ_MASK;
  wire        wr_cfg   = wr_acc && avs_address_in == nes_pkg::OFS_CONFIG;
  wire [7:0]  wd       = avs_writedata_in[7:0];
  wire        lane0    = avs_byteenable_in[0];
  wire        lane1    = avs_byteenable_in[1];
  wire        idle     = state == nes_pkg::ST_IDLE;
  // Launch is writing a one to the complete flag while it is set.
  wire        launch   = wr_stat && lane0 && wd[nes_pkg::BIT_COMPLETE]
                         && command_complete_flag && idle;

  wire [7:0]  cmd      = command_parameter_words[nes_pkg::IDX_FIRST][15:8];
  wire [7:0]  blk      = command_parameter_words[nes_pkg::IDX_FIRST][7:0];
  wire [1:0]  low_addr = command_parameter_words[nes_pkg::IDX_SECOND][1:0];
  wire        is_blk   = cmd == nes_pkg::CMD_ERASE_BLOCK;
  wire        is_sec   = cmd == nes_pkg::CMD_ERASE_SECTOR;
  wire        is_uns   = cmd == nes_pkg::CMD_UNSECURE;
  wire        to_ee    = blk[7];
  wire        blk_ok   = blk == nes_pkg::BLK_FLASH
                         || blk == nes_pkg::BLK_EE;
  wire        prot_sel = to_ee ? cfg[nes_pkg::BIT_PROT_EE]
                               : cfg[nes_pkg::BIT_PROT_FLASH];
  wire        prot_any = cfg[nes_pkg::BIT_PROT_EE]
                         || cfg[nes_pkg::BIT_PROT_FLASH];
  wire        mode_ok  = cfg[nes_pkg::BIT_MODE_OK];

  // Unknown codes are left to the other command logic, so only the
  // three handled here raise errors.
  wire        acc_bad  =
      ((is_blk || is_sec)
         && command_word_index != nes_pkg::IDX_SECOND)
      || ((is_blk || is_sec || is_uns) && !mode_ok)
      || ((is_blk || is_sec) && !blk_ok)
      || (is_sec && low_addr != nes_pkg::ALIGN_OK)
      || (is_uns && command_word_index != nes_pkg::IDX_FIRST);
  wire        prot_bad =
      (is_blk && prot_sel)
      || (is_sec && prot_sel)
      || (is_uns && prot_any);
  nes_pkg::nes_check_type chk;
  assign chk = '{access_err: acc_bad, prot_viol: prot_bad};

  wire        run_ok   = (is_blk || is_sec || is_uns)
                         && !chk.access_err && !chk.prot_viol;
  wire [CW-1:0] blk_len = to_ee ? CW'(EE_WORDS) : CW'(FLASH_WORDS);
  wire [CW-1:0] span    = is_uns ? CW'(FLASH_WORDS + EE_WORDS)
                        : is_sec ? CW'(SECTOR_WORDS) : blk_len;
  wire        tick_end = tick_cnt == 8'(nes_pkg::ERASE_CYC_PER_ADDR - 1);
  wire        cnt_end  = work_cnt == CW'(1) && tick_end;

  nes_pkg::nes_verify_type vres;
  assign vres = '{verr: cfg[nes_pkg::BIT_FAIL_VER]
                        || cfg[nes_pkg::BIT_FAIL_UNC],
                  vunc: cfg[nes_pkg::BIT_FAIL_UNC]};

  // Next state: erase then verify walk the same span of addresses.
  nes_pkg::nes_state_type next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      nes_pkg::ST_IDLE:
        if (launch && run_ok) begin
          next_state = nes_pkg::ST_ERASE;
        end
      nes_pkg::ST_ERASE:
        if (cnt_end) begin
          next_state = nes_pkg::ST_VERIFY;
        end
      nes_pkg::ST_VERIFY:
        if (cnt_end) begin
          next_state = nes_pkg::ST_FINISH;
        end
      nes_pkg::ST_FINISH:
        next_state = nes_pkg::ST_IDLE;
      default:
        next_state = nes_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state    <= nes_pkg::ST_IDLE;
      work_cnt <= '0;
      tick_cnt <= '0;
      is_unsec <= 1'b0;
    end else begin
      state <= next_state;
      if (launch) begin
        work_cnt <= span;
        tick_cnt <= '0;
        is_unsec <= is_uns;
      end else if (state == nes_pkg::ST_ERASE
                   || state == nes_pkg::ST_VERIFY) begin
        tick_cnt <= tick_end ? 8'h00 : tick_cnt + 8'h01;
        if (tick_end) begin
          work_cnt <= cnt_end ? span : work_cnt - CW'(1);
        end
      end
    end
  end

  // Index and parameter words; writes while busy are ignored.
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      command_word_index <= nes_pkg::IDX_FIRST;
      for (int i = 0; i < 8; i++) begin
        command_parameter_words[i] <= 16'h0000;
      end
    end else if (idle) begin
      if (wr_idx && lane0) begin
        command_word_index <= wd[2:0];
      end
      if (wr_par) begin
        if (lane0) begin
          command_parameter_words[command_word_index][7:0] <=
            avs_writedata_in[7:0];
        end
        if (lane1) begin
          command_parameter_words[command_word_index][15:8] <=
            avs_writedata_in[15:8];
        end
      end
    end
  end

  wire clr_acc = wr_stat && lane0 && wd[nes_pkg::BIT_ACC_ERR];
  wire clr_fpv = wr_stat && lane0 && wd[nes_pkg::BIT_PROT_VIOL];
  wire v_end   = state == nes_pkg::ST_VERIFY && cnt_end;

  // Status flags; a hardware set wins over a software clear.
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      command_complete_flag     <= 1'b1;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag         <= 1'b0;
      verify_uncorrectable_flag <= 1'b0;
    end else begin
      if (launch) begin
        command_complete_flag <= !run_ok;
      end else if (state == nes_pkg::ST_FINISH) begin
        command_complete_flag <= 1'b1;
      end
      if (launch && chk.access_err) begin
        access_error_flag <= 1'b1;
      end else if (clr_acc) begin
        access_error_flag <= 1'b0;
      end
      if (launch && chk.prot_viol) begin
        protection_violation_flag <= 1'b1;
      end else if (clr_fpv) begin
        protection_violation_flag <= 1'b0;
      end
      if (launch) begin
        verify_error_flag         <= 1'b0;
        verify_uncorrectable_flag <= 1'b0;
      end else if (v_end) begin
        verify_error_flag         <= vres.verr;
        verify_uncorrectable_flag <= vres.vunc;
      end
    end
  end

  // Security is set at reset and only released by a clean unsecure.
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      secure <= 1'b1;
    end else if (v_end && is_unsec && !vres.verr) begin
      secure <= 1'b0;
    end
  end

  // Configuration and interrupt logic on one completion event.
  wire done_evt = (!command_complete_flag && state == nes_pkg::ST_FINISH)
                  || (launch && !run_ok);
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg         <= nes_pkg::CFG_RESET;
      done_sticky <= 1'b0;
      done_mask   <= 1'b0;
    end else begin
      // Config writes while busy are dropped, which covers hosts that
      // break the no-write rule during unsecure.
      if (wr_cfg && lane0 && idle) begin
        cfg <= wd;
      end
      if (wr_mask && lane0) begin
        done_mask <= wd[nes_pkg::BIT_DONE];
      end
      if (done_evt) begin
        done_sticky <= 1'b1;
      end else if (wr_acc && lane0 && wd[nes_pkg::BIT_DONE]
                   && avs_address_in == nes_pkg::OFS_SECURITY) begin
        done_sticky <= 1'b0;
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_in)
      nes_pkg::OFS_STATUS: begin
        rd_mux[nes_pkg::BIT_COMPLETE]  = command_complete_flag;
        rd_mux[nes_pkg::BIT_ACC_ERR]   = access_error_flag;
        rd_mux[nes_pkg::BIT_PROT_VIOL] = protection_violation_flag;
        rd_mux[nes_pkg::BIT_VERR]      = verify_error_flag;
        rd_mux[nes_pkg::BIT_VUNC]      = verify_uncorrectable_flag;
      end
      nes_pkg::OFS_INDEX:    rd_mux[2:0] = command_word_index;
      nes_pkg::OFS_PARAM:
        rd_mux[15:0] = command_parameter_words[command_word_index];
      nes_pkg::OFS_IRQ_MASK: rd_mux[nes_pkg::BIT_DONE] = done_mask;
      nes_pkg::OFS_CONFIG:   rd_mux[7:0] = cfg;
      nes_pkg::OFS_SECURITY: begin
        rd_mux[nes_pkg::BIT_DONE] = done_sticky;
        rd_mux[nes_pkg::BIT_SECURE] = secure;
      end
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access keeps read data registered.
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      irq_out             <= 1'b0;
      secure_out          <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in)
                               && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
      irq_out    <= (done_sticky || done_evt) && done_mask;
      secure_out <= secure;
    end
  end

  a_launch_runs: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    launch && run_ok |=> state == nes_pkg::ST_ERASE
      && !command_complete_flag)
    else $error("good launch did not start erase");
  a_bad_done: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    launch && (chk.access_err || chk.prot_viol) |=> command_complete_flag
      && idle)
    else $error("failed check did not complete at once");
  a_acc_set: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    launch && chk.access_err |=> access_error_flag)
    else $error("access error not raised");
  a_prot_set: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    launch && chk.prot_viol |=> protection_violation_flag)
    else $error("protection violation not raised");
  a_secure_keep: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    $fell(secure) |-> $past(is_unsec) && !$past(vres.verr))
    else $error("security released without clean unsecure");
  a_verify_flag: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    v_end && vres.verr |=> verify_error_flag)
    else $error("verify error not reported");
  a_finish_complete: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    state == nes_pkg::ST_FINISH |=> command_complete_flag && idle)
    else $error("complete flag not set after verify");
  a_busy_incomplete: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    state == nes_pkg::ST_ERASE |-> !command_complete_flag)
    else $error("complete flag set during erase");
  a_mode_refused: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    launch && (is_blk || is_sec || is_uns) && !mode_ok
      |=> access_error_flag)
    else $error("command in a barred mode not refused");
  a_sector_prot: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    launch && is_sec && prot_sel |=> protection_violation_flag)
    else $error("protected sector not refused");
  a_verify_unc: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    v_end && vres.vunc |=> verify_uncorrectable_flag)
    else $error("uncorrectable verify error not reported");
  a_unsec_keep: assert property (@(posedge sys_clk_in)
    disable iff (!rst_sync_b)
    v_end && is_unsec && vres.verr |=> $stable(secure))
    else $error("failed unsecure changed security");
  c_block: cover property (@(posedge sys_clk_in) launch && is_blk && run_ok);
  c_sector: cover property (@(posedge sys_clk_in) launch && is_sec && run_ok);
  c_unsec: cover property (@(posedge sys_clk_in) $fell(secure));
  c_acc: cover property (@(posedge sys_clk_in) launch && chk.access_err);
  c_prot: cover property (@(posedge sys_clk_in) launch && chk.prot_viol);
endmodule
`default_nettype wire

// >>> tb/tb_nes_erase_seq.sv
/*
  Self-checking bench for the erase and unsecure command sequencer.
  Assumes the sequencer's Avalon-MM slave answers every request and that
  the count parameters are shrunk to 4 so that each command runs briefly.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_nes_erase_seq;
  logic        sys_clk_in;
  logic        rst_b_in;
  logic [3:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        irq_out;
  logic        secure_out;
  logic [63:0] expq[$];
  logic [63:0] note;
  logic [31:0] dummy;
  int          n_errors;
  int          num_checks;
  int          seed;

  nes_erase_seq #(
    .FLASH_WORDS  (4),
    .EE_WORDS     (4),
    .SECTOR_WORDS (4)
  ) u_nes_erase_seq (
    .sys_clk_in          (sys_clk_in),
    .rst_b_in            (rst_b_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .irq_out             (irq_out),
    .secure_out          (secure_out)
  );

  always #12.5 sys_clk_in = ~sys_clk_in;

  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads leave their expectation in the queue; a zero mask means a poll.
  always @(posedge sys_clk_in) begin
    if (avs_read_in === 1'h1 && avs_waitrequest_out === 1'h0) begin
      note = expq.pop_front();
      if (note[31:0] !== 32'h0) begin
        compare(avs_readdata_out & note[31:0], note[63:32]);
      end
    end
  end

  task automatic bus_op(input logic wr_en, input logic [3:0] a,
                        input logic [31:0] d, input logic [31:0] e,
                        input logic [31:0] m, output logic [31:0] r);
    @(posedge sys_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_read_in      <= !wr_en;
    avs_write_in     <= wr_en;
    if (!wr_en) begin
      expq.push_back({e, m});
    end
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'h0);
    r = avs_readdata_out;
    avs_read_in  <= 1'h0;
    avs_write_in <= 1'h0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus_op(1'h1, a, d, 32'h0, 32'h0, dummy);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    bus_op(1'h0, a, 32'h0, e, m, dummy);
  endtask

  // Only reads while busy, so the host never writes during a command.
  task automatic wait_done();
    logic [31:0] r;
    int          n;
    r = 32'h0;
    n = 0;
    while (r[7] !== 1'h1 && n < 300) begin
      bus_op(1'h0, nes_pkg::OFS_STATUS, 32'h0, 32'h0, 32'h0, r);
      n++;
    end
    if (r[7] !== 1'h1) begin
      compare(r, 32'h80);
    end
  endtask

  task automatic run_cmd(input logic [7:0] code, input logic [7:0] blk,
                         input logic [15:0] lo, input logic [2:0] idx,
                         input logic [7:0] cfg, input logic [7:0] st,
                         input logic sec);
    wr(nes_pkg::OFS_CONFIG, {24'h0, cfg});
    wr(nes_pkg::OFS_INDEX, 32'h0);
    wr(nes_pkg::OFS_PARAM, {16'h0, code, blk});
    wr(nes_pkg::OFS_INDEX, 32'h1);
    wr(nes_pkg::OFS_PARAM, {16'h0, lo});
    wr(nes_pkg::OFS_INDEX, {29'h0, idx});
    wr(nes_pkg::OFS_STATUS, 32'h30);
    wr(nes_pkg::OFS_SECURITY, 32'h1);
    wr(nes_pkg::OFS_STATUS, 32'h80);
    // A refused launch must already show complete with its flag.
    if (st[5] || st[4]) begin
      rd(nes_pkg::OFS_STATUS, {24'h0, st}, 32'hB3);
    end else begin
      rd(nes_pkg::OFS_STATUS, 32'h0, 32'h80);
    end
    wait_done();
    rd(nes_pkg::OFS_STATUS, {24'h0, st}, 32'hB3);
    rd(nes_pkg::OFS_SECURITY, {30'h0, sec, 1'h0}, 32'h2);
  endtask

  function automatic logic [15:0] rnd_al();
    return 16'($random(seed)) & 16'hFFFC;
  endfunction

  initial begin
    sys_clk_in        = 1'h0;
    rst_b_in          = 1'h0;
    avs_address_in    = 4'h0;
    avs_read_in       = 1'h0;
    avs_write_in      = 1'h0;
    avs_writedata_in  = 32'h0;
    avs_byteenable_in = 4'hF;
    n_errors          = 0;
    num_checks        = 0;
    seed              = 49;
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'h1;
    repeat (3) @(posedge sys_clk_in);
    rd(nes_pkg::OFS_STATUS, 32'h80, 32'hB3);
    rd(nes_pkg::OFS_CONFIG, 32'h4, 32'h1F);
    rd(nes_pkg::OFS_SECURITY, 32'h2, 32'h3);
    rd(nes_pkg::OFS_IRQ_MASK, 32'h0, 32'h1);
    rd(nes_pkg::OFS_INDEX, 32'h0, 32'h7);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0, 32'hFFFF_FFFF);
    // Operands: code, block, word one, index, config, status, secure.
    run_cmd(8'h09, 8'h00, rnd_al(), 3'h1, 8'h04, 8'h80, 1'h1);
    compare({31'h0, irq_out}, 32'h0);
    wr(nes_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (3) @(posedge sys_clk_in);
    compare({31'h0, irq_out}, 32'h1);
    wr(nes_pkg::OFS_SECURITY, 32'h1);
    repeat (3) @(posedge sys_clk_in);
    compare({31'h0, irq_out}, 32'h0);
    wr(nes_pkg::OFS_IRQ_MASK, 32'h0);
    run_cmd(8'h09, 8'h80, rnd_al(), 3'h1, 8'h04, 8'h80, 1'h1);
    run_cmd(8'h09, 8'h00, rnd_al(), 3'h2, 8'h04, 8'hA0, 1'h1);
    run_cmd(8'h09, 8'h00, rnd_al(), 3'h1, 8'h00, 8'hA0, 1'h1);
    run_cmd(8'h09, 8'h40, rnd_al(), 3'h1, 8'h04, 8'hA0, 1'h1);
    run_cmd(8'h09, 8'h00, rnd_al(), 3'h1, 8'h05, 8'h90, 1'h1);
    run_cmd(8'h09, 8'h80, rnd_al(), 3'h1, 8'h05, 8'h80, 1'h1);
    run_cmd(8'h09, 8'h00, rnd_al(), 3'h1, 8'h0C, 8'h82, 1'h1);
    run_cmd(8'h0A, 8'h80, rnd_al(), 3'h1, 8'h14, 8'h83, 1'h1);
    run_cmd(8'h0A, 8'h00, rnd_al(), 3'h1, 8'h04, 8'h80, 1'h1);
    run_cmd(8'h0A, 8'h00, rnd_al() | 16'h2, 3'h1, 8'h04, 8'hA0,
            1'h1);
    run_cmd(8'h0A, 8'h80, rnd_al(), 3'h1, 8'h06, 8'h90, 1'h1);
    run_cmd(8'h0A, 8'h00, rnd_al(), 3'h0, 8'h04, 8'hA0, 1'h1);
    run_cmd(8'h0A, 8'h00, rnd_al(), 3'h1, 8'h00, 8'hA0, 1'h1);
    run_cmd(8'h0B, 8'h5A, rnd_al(), 3'h1, 8'h04, 8'hA0, 1'h1);
    run_cmd(8'h0B, 8'h5A, rnd_al(), 3'h0, 8'h06, 8'h90, 1'h1);
    run_cmd(8'h0B, 8'h5A, rnd_al(), 3'h0, 8'h00, 8'hA0, 1'h1);
    run_cmd(8'h0B, 8'h5A, rnd_al(), 3'h0, 8'h0C, 8'h82, 1'h1);
    compare({31'h0, secure_out}, 32'h1);
    run_cmd(8'h0B, 8'h5A, rnd_al(), 3'h0, 8'h04, 8'h80, 1'h0);
    compare({31'h0, secure_out}, 32'h0);
    end_of_test();
  end

  // Each command takes about a hundred cycles at most, so this span is generous.
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
